// ### rcs_consts.vh
// constants for the reset configuration sequencer
// Functional notes
// RULE_01: primary clock comes from primary input in host mode, agent clock in agent mode.
// RULE_02: outside party holds hard reset low at least 32 sync periods.
// RULE_03: host mode: power-on reset held at least 32 primary periods.
// RULE_04: agent mode: power-on reset held at least 32 sync periods.
// RULE_05: device-driven hard reset stays asserted a long fixed minimum of sync periods.
// RULE_06: at least 16 sync periods from hard reset release to soft reset release.
// RULE_07: configuration inputs valid at least 4 periods before power-on reset negates.
// RULE_08: configuration inputs stay stable until hard reset negates.
// RULE_09: shared configuration pins released immediately when hard reset asserts.
// RULE_10: functional drive on shared pins waits 1 sync period after hard reset.
// RULE_11: sample four-bit reset source, clock divide select and local bus mux select.
// RULE_12: host mode sync period derives from primary clock scaled by divide select.
// RULE_13: wait 100 us for PLL lock before clocks count as stable.
// RULE_14: hard and soft reset are open-drain, pulled low only; power-on input only.
`ifndef RCS_CONSTS_VH
`define RCS_CONSTS_VH
`define RCS_CLK_MHZ        40
`define RCS_POR_MIN        32
`define RCS_HRST_IN_MIN    32
`define RCS_HRST_OUT_MIN   512
`define RCS_HRST_TO_SRST   16
`define RCS_CFG_SETUP      4
`define RCS_FUNC_DELAY     1
`define RCS_PLL_LOCK_US    100
`define RCS_PLL_LOCK_CYC   (`RCS_PLL_LOCK_US * `RCS_CLK_MHZ)
`define RCS_DIV_NORMAL     1
`define RCS_DIV_SCALED     2
`endif

// ### rcs_sync_tick.v
// sync-clock tick generator driven by the selected primary or agent clock edge
`timescale 1ns/100ps
`include "rcs_consts.vh"
module rcs_sync_tick (
	clk,
	nrst,
	src_tick,
	div_two,
	sync_tick
);
	input  wire clk;
	input  wire nrst;
	input  wire src_tick;
	input  wire div_two;
	output reg  sync_tick;

	reg ph_q;

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ph_q      <= 1'b0;
			sync_tick <= 1'b0;
		end else begin
			sync_tick <= 1'b0;
			if (src_tick) begin
				// divide select scales the sync period, see RULE_12
				if (div_two) begin
					ph_q      <= ~ph_q;
					sync_tick <= ph_q;
				end else begin
					sync_tick <= 1'b1;
				end
			end
		end
	end
endmodule // rcs_sync_tick

// ### rcs_sequencer.v
// reset configuration sequencer top
`timescale 1ns/100ps
`include "rcs_consts.vh"
module rcs_sequencer #(
	parameter HRST_OUT_MIN = `RCS_HRST_OUT_MIN,
	parameter PLL_LOCK_CYC = `RCS_PLL_LOCK_CYC
) (
	clk,
	nrst,
	agent_mode,
	primary_clock_in,
	agent_clock_in,
	power_on_reset_in_n,
	hard_reset_line_in,
	soft_reset_line_in,
	sw_hard_reset_req,
	cfg_reset_source_in,
	input_clock_divide_select,
	local_bus_mux_select,
	hard_reset_line_o,
	hard_reset_line_oe,
	soft_reset_line_o,
	soft_reset_line_oe,
	cfg_pins_oe,
	cfg_reset_source_q,
	clk_div_sel_q,
	lbmux_sel_q,
	clocks_stable,
	sync_tick_o
);
	input  wire       clk;
	input  wire       nrst;
	input  wire       agent_mode;
	input  wire       primary_clock_in;
	input  wire       agent_clock_in;
	input  wire       power_on_reset_in_n;
	input  wire       hard_reset_line_in;
	input  wire       soft_reset_line_in;
	input  wire       sw_hard_reset_req;
	input  wire [3:0] cfg_reset_source_in;
	input  wire       input_clock_divide_select;
	input  wire       local_bus_mux_select;
	output reg        hard_reset_line_o;
	output reg        hard_reset_line_oe;
	output reg        soft_reset_line_o;
	output reg        soft_reset_line_oe;
	output reg        cfg_pins_oe;
	output reg  [3:0] cfg_reset_source_q;
	output reg        clk_div_sel_q;
	output reg        lbmux_sel_q;
	output reg        clocks_stable;
	output wire       sync_tick_o;

	localparam [4:0] ST_POR  = 5'h01;
	localparam [4:0] ST_PLL  = 5'h02;
	localparam [4:0] ST_HRST = 5'h04;
	localparam [4:0] ST_GAP  = 5'h08;
	localparam [4:0] ST_RUN  = 5'h10;

	reg  [4:0]  st_q;
	reg  [19:0] cnt_q;
	reg  [5:0]  por_cnt_q;
	reg  [5:0]  hin_cnt_q;
	reg         pclk_q;
	reg         aclk_q;
	reg         por_ok_q;
	reg         func_wait_q;
	wire        p_rise;
	wire        a_rise;
	wire        src_tick;
	wire        sync_tick;
	wire        por_tick;
	wire        ext_hrst;

	// ------------------------------------------------------------
	// clock source selection
	// ------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pclk_q <= 1'b0;
			aclk_q <= 1'b0;
		end else begin
			pclk_q <= primary_clock_in;
			aclk_q <= agent_clock_in;
		end
	end
	assign p_rise   = primary_clock_in & ~pclk_q;
	assign a_rise   = agent_clock_in & ~aclk_q;
	assign src_tick = agent_mode ? a_rise : p_rise; // see RULE_01

	rcs_sync_tick u_tick (
		.clk       (clk),
		.nrst      (nrst),
		.src_tick  (src_tick),
		.div_two   (clk_div_sel_q & ~agent_mode),
		.sync_tick (sync_tick)
	);
	assign sync_tick_o = sync_tick;

	// power-on qualification counts primary periods in host mode
	assign por_tick = agent_mode ? sync_tick : p_rise; // see RULE_03
	assign ext_hrst = ~hard_reset_line_in & ~hard_reset_line_oe;

	// ------------------------------------------------------------
	// power-on and external hard reset qualification
	// ------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			por_cnt_q <= 6'h00;
			por_ok_q  <= 1'b0;
			hin_cnt_q <= 6'h00;
		end else begin
			if (!power_on_reset_in_n) begin
				// assertion shorter than the minimum is ignored only until por_ok_q is first set, see RULE_04
				if (por_tick && por_cnt_q != `RCS_POR_MIN)
					por_cnt_q <= por_cnt_q + 6'h01;
				if (por_cnt_q == `RCS_POR_MIN)
					por_ok_q <= 1'b1;
			end else begin
				por_cnt_q <= 6'h00;
			end
			if (ext_hrst) begin
				if (sync_tick && hin_cnt_q != `RCS_HRST_IN_MIN)
					hin_cnt_q <= hin_cnt_q + 6'h01; // see RULE_02
			end else begin
				hin_cnt_q <= 6'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q               <= ST_POR;
			cnt_q              <= 20'h00000;
			hard_reset_line_o  <= 1'b0;
			hard_reset_line_oe <= 1'b1;
			soft_reset_line_o  <= 1'b0;
			soft_reset_line_oe <= 1'b1;
			cfg_pins_oe        <= 1'b0;
			cfg_reset_source_q <= 4'h0;
			clk_div_sel_q      <= 1'b0;
			lbmux_sel_q        <= 1'b0;
			clocks_stable      <= 1'b0;
			func_wait_q        <= 1'b0;
		end else begin
			hard_reset_line_o <= 1'b0;
			soft_reset_line_o <= 1'b0;
			case (st_q)
			ST_POR: begin
				cfg_pins_oe   <= 1'b0;
				clocks_stable <= 1'b0;
				// straps are taken on power-on release, see RULE_07
				if (por_ok_q && power_on_reset_in_n) begin
					cfg_reset_source_q <= cfg_reset_source_in; // see RULE_11
					clk_div_sel_q      <= input_clock_divide_select;
					lbmux_sel_q        <= local_bus_mux_select;
					cnt_q              <= 20'h00000;
					st_q               <= ST_PLL;
				end
			end
			ST_PLL: begin
				cnt_q <= cnt_q + 20'h00001;
				if (cnt_q == PLL_LOCK_CYC - 1) begin
					clocks_stable <= 1'b1; // see RULE_13
					cnt_q         <= 20'h00000;
					st_q          <= ST_HRST;
				end
			end
			ST_HRST: begin
				if (sync_tick)
					cnt_q <= cnt_q + 20'h00001;
				if (cnt_q == HRST_OUT_MIN) begin // see RULE_05
					hard_reset_line_oe <= 1'b0; // see RULE_14
					cnt_q              <= 20'h00000;
					func_wait_q        <= 1'b1;
					st_q               <= ST_GAP;
				end
			end
			ST_GAP: begin
				if (sync_tick) begin
					cnt_q <= cnt_q + 20'h00001;
					if (func_wait_q) begin
						func_wait_q <= 1'b0;
						cfg_pins_oe <= 1'b1; // see RULE_10
					end
				end
				if (cnt_q == `RCS_HRST_TO_SRST) begin // see RULE_06
					soft_reset_line_oe <= 1'b0;
					st_q               <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (sw_hard_reset_req || hin_cnt_q == `RCS_HRST_IN_MIN) begin
					hard_reset_line_oe <= 1'b1;
					soft_reset_line_oe <= 1'b1;
					cfg_pins_oe        <= 1'b0; // see RULE_09
					cnt_q              <= 20'h00000;
					st_q               <= ST_HRST;
				end
			end
			default: begin
				st_q <= ST_POR;
			end
			endcase
			if (!power_on_reset_in_n) begin
				st_q               <= ST_POR;
				hard_reset_line_oe <= 1'b1;
				soft_reset_line_oe <= 1'b1;
				cfg_pins_oe        <= 1'b0;
				clocks_stable      <= 1'b0;
			end
		end
	end
endmodule // rcs_sequencer

// ### rcs_sequencer_props.sv
// assertion checker for the reset configuration sequencer
`timescale 1ns/100ps
module rcs_seq_props #(
	parameter HRST_OUT_MIN = 4,
	parameter PLL_LOCK_CYC = 10
) (
	input wire       clk,
	input wire       nrst,
	input wire       power_on_reset_in_n,
	input wire       hard_reset_line_o,
	input wire       hard_reset_line_oe,
	input wire       soft_reset_line_o,
	input wire       soft_reset_line_oe,
	input wire       cfg_pins_oe,
	input wire [3:0] cfg_reset_source_q,
	input wire       clocks_stable,
	input wire       sync_tick_o
);
	logic [15:0] hold_ticks;
	logic [15:0] gap_ticks;

	// sync ticks seen while hard reset is pulled, and since it was let go
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hold_ticks <= 16'h0000;
			gap_ticks  <= 16'h0000;
		end else begin
			if (!hard_reset_line_oe)
				hold_ticks <= 16'h0000;
			else if (sync_tick_o && hold_ticks != 16'hffff)
				hold_ticks <= hold_ticks + 16'h0001;
			if (hard_reset_line_oe)
				gap_ticks <= 16'h0000;
			else if (sync_tick_o && gap_ticks != 16'hffff)
				gap_ticks <= gap_ticks + 16'h0001;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_drive_low_only:
		assert property (!hard_reset_line_o && !soft_reset_line_o)
		else $error("reset line driven high");
	a_cfg_off_hard:
		assert property (hard_reset_line_oe |-> !cfg_pins_oe)
		else $error("shared pins driven in hard reset");
	a_cfg_after_hard:
		assert property ($rose(cfg_pins_oe) |-> !$past(hard_reset_line_oe))
		else $error("shared pins driven too early");
	a_hard_min_hold:
		assert property ($fell(hard_reset_line_oe)
			|-> $past(hold_ticks) >= HRST_OUT_MIN)
		else $error("hard reset released too soon");
	a_soft_after_hard:
		assert property ($fell(soft_reset_line_oe)
			|-> $past(gap_ticks) >= 16)
		else $error("soft reset released too soon");
	a_pll_wait:
		assert property ($rose(clocks_stable)
			|-> $past(power_on_reset_in_n, PLL_LOCK_CYC - 1))
		else $error("clocks stable too early");
	a_hard_till_stable:
		assert property (!clocks_stable |-> hard_reset_line_oe)
		else $error("hard reset released before lock");
	a_straps_hold:
		assert property (clocks_stable && $past(clocks_stable)
			|-> $stable(cfg_reset_source_q))
		else $error("sampled straps changed");
	a_tick_pulse:
		assert property (sync_tick_o |=> !sync_tick_o)
		else $error("sync tick longer than one cycle");
endmodule // rcs_seq_props

bind rcs_sequencer rcs_seq_props #(.HRST_OUT_MIN(HRST_OUT_MIN),
	.PLL_LOCK_CYC(PLL_LOCK_CYC)) i_rcs_seq_props (.clk(clk), .nrst(nrst),
	.power_on_reset_in_n(power_on_reset_in_n),
	.hard_reset_line_o(hard_reset_line_o),
	.hard_reset_line_oe(hard_reset_line_oe),
	.soft_reset_line_o(soft_reset_line_o),
	.soft_reset_line_oe(soft_reset_line_oe), .cfg_pins_oe(cfg_pins_oe),
	.cfg_reset_source_q(cfg_reset_source_q), .clocks_stable(clocks_stable),
	.sync_tick_o(sync_tick_o));

// ### rcs_board_model.sv
// board model: free input clocks, power-on reset and strap pins
`timescale 1ns/100ps
module rcs_board_model (
	input  wire        clk,
	input  wire        start,
	input  wire  [5:0] straps,
	input  wire        hard_line,
	output logic       prim_clk,
	output logic       agent_clk,
	output logic       por_n,
	output logic [5:0] strap_pins
);
	int         n = 0;
	logic [7:0] cnt = 0;
	initial {prim_clk, agent_clk, por_n, strap_pins} = '0;
	always @(posedge clk) begin
		n <= n + 1;
		prim_clk <= (n % 4) < 2;
		agent_clk <= (n % 6) < 3;
		if (start) begin
			por_n <= 0;
			cnt <= 0;
			strap_pins <= straps;
		end else if (!por_n && n % 4 == 0) begin
			cnt <= cnt + 1;
			por_n <= cnt == 80;
		end else if (por_n && hard_line)
			strap_pins <= ~straps;
	end
endmodule // rcs_board_model

// ### rcs_sequencer_bench.sv
// self-checking bench for the reset configuration sequencer
`timescale 1ns/100ps
module rcs_sequencer_bench;
	logic        clk, nrst, agent, start, sw_req, ext_n, a, d;
	logic [5:0]  straps;
	logic [31:0] seed;
	wire         prim, agc, por_n, h_o, h_oe, s_o, s_oe, cfg_oe;
	wire         div_q, lb_q, stable, tick;
	wire  [3:0]  src_q;
	wire  [5:0]  pins;
	wire         hard_line = (h_oe ? h_o : 1'b1) & ext_n;
	wire         soft_line = s_oe ? s_o : 1'b1;
	int          failures = 0, checked = 0, n, k;
	rcs_sequencer #(.HRST_OUT_MIN(4), .PLL_LOCK_CYC(10)) i_rcs_sequencer (
		.clk(clk), .nrst(nrst), .agent_mode(agent), .primary_clock_in(prim),
		.agent_clock_in(agc), .power_on_reset_in_n(por_n),
		.hard_reset_line_in(hard_line), .soft_reset_line_in(soft_line),
		.sw_hard_reset_req(sw_req), .cfg_reset_source_in(pins[3:0]),
		.input_clock_divide_select(pins[4]), .local_bus_mux_select(pins[5]),
		.hard_reset_line_o(h_o), .hard_reset_line_oe(h_oe),
		.soft_reset_line_o(s_o), .soft_reset_line_oe(s_oe),
		.cfg_pins_oe(cfg_oe), .cfg_reset_source_q(src_q),
		.clk_div_sel_q(div_q), .lbmux_sel_q(lb_q), .clocks_stable(stable),
		.sync_tick_o(tick));
	rcs_board_model i_rcs_board_model (.clk(clk), .start(start),
		.straps(straps), .hard_line(hard_line), .prim_clk(prim),
		.agent_clk(agc), .por_n(por_n), .strap_pins(pins));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task conclude;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 20000);
		failures++;
		conclude;
	end
	initial begin
		{nrst, agent, start, sw_req, straps} = '0;
		ext_n = 1;
		seed = 32'hbac3;
		repeat (8) @(posedge clk);
		nrst <= 1;
		for (int r = 0; r < 4; r++) begin
			seed = xs(seed);
			a = (r < 3) ? (r == 2) : seed[8];
			d = (r < 3) ? (r == 1) : seed[4];
			@(posedge clk);
			agent <= a;
			straps <= {seed[5], d, seed[3:0]};
			start <= 1;
			@(posedge clk);
			start <= 0;
			repeat (4) @(negedge clk);
			for (k = 0; k < 800 && stable !== 1'b1; k++) @(negedge clk);
			chk("straps", {2'b0, straps}, {2'b0, lb_q, div_q, src_q});
			for (k = 0; k < 400 && h_oe !== 1'b0; k++) @(negedge clk);
			chk("cfg_early", 8'h0, {7'h0, cfg_oe});
			n = 0;
			for (k = 0; k < 400 && s_oe !== 1'b0; k++) begin
				@(negedge clk);
				n += (tick === 1'b1);
			end
			chk("soft_gap", 8'h1, {7'h0, n >= 16});
			chk("cfg_late", 8'h1, {7'h0, cfg_oe});
			for (k = 0; k < 20 && tick !== 1'b1; k++) @(negedge clk);
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (tick !== 1'b1 && n < 20);
			chk("tick_gap", a ? 8'd6 : (d ? 8'd8 : 8'd4), n[7:0]);
			@(posedge clk);
			ext_n <= 0;
			repeat (3) @(posedge clk);
			ext_n <= 1;
			repeat (4) @(negedge clk);
			chk("short_hrst", 8'h1, {7'h0, cfg_oe});
			@(posedge clk);
			ext_n <= 0;
			for (k = 0; k < 400 && h_oe !== 1'b1; k++) @(posedge clk);
			ext_n <= 1;
			@(negedge clk);
			chk("long_hrst", 8'h1, {7'h0, h_oe});
			for (k = 0; k < 400 && s_oe !== 1'b0; k++) @(negedge clk);
			chk("long_soft", 8'h0, {7'h0, s_oe});
			@(posedge clk);
			sw_req <= 1;
			@(posedge clk);
			sw_req <= 0;
			repeat (3) @(negedge clk);
			chk("sw_hrst", 8'h3, {6'h0, h_oe, ~cfg_oe});
		end
		conclude;
	end
endmodule // rcs_sequencer_bench
